// [include/sar_readout_defs.svh]
// Constants for the converter control and serial readout block.
`ifndef SAR_READOUT_DEFS_SVH
`define SAR_READOUT_DEFS_SVH

// ----------------------------------------------------------------------
// Word and frame layout
// ----------------------------------------------------------------------
`define RESULT_WIDTH 18
`define FRAME_WIDTH 20
`define SIGN_MASK 18'h20000
`define SELF_HEADER 2'h2
`define SELF_LAST 5'h13
`define ECHO_LAST 5'h11
`define TOP_INDEX 5'h11

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLOCK_PERIOD_NS 4
`define MSB_READY_NS 100
`define CONV_PERIOD_NS 200
`define SYNC_LATENCY 3
`define MSB_READY_COUNT \
  6'(((`MSB_READY_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS) - `SYNC_LATENCY)
`define CONV_PERIOD_COUNT \
  6'((`CONV_PERIOD_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define STRAP_COUNT 6'h04

`endif

// [include/sar_readout_pkg.sv]
// Types shared by the converter control and serial readout block.
`include "sar_readout_defs.svh"

package sar_readout_pkg;

  // --------------------------------------------------------------------
  // Control sequencer states, one-hot
  // --------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_STRAP   = 4'h1,
    ST_ACQUIRE = 4'h2,
    ST_CONVERT = 4'h4,
    ST_HOLDOFF = 4'h8
  } ctrl_state_t;

  // Main-domain state of the sequencer.
  typedef struct packed {
    ctrl_state_t                state;
    logic                       start_prev;
    logic [5:0]                 timer;
    logic [`RESULT_WIDTH-1:0]   result_word;
    logic                       word_toggle;
    logic                       echo_mode;
  } ctrl_t;

  // Shift-clock-domain state of the serial output.
  typedef struct packed {
    logic                       seen_toggle;
    logic [4:0]                 remaining;
    logic [`FRAME_WIDTH-1:0]    shreg;
    logic                       serial_data;
  } link_t;

  // Successive approximation engine state.
  typedef struct packed {
    logic                       busy;
    logic [4:0]                 index;
    logic [`RESULT_WIDTH-1:0]   sample;
    logic [`RESULT_WIDTH-1:0]   code;
    logic                       done;
  } sar_t;

endpackage : sar_readout_pkg

// [src/sync2.sv]
// Two flip-flop synchroniser for levels arriving from outside the clock domain.
`timescale 1ns/1ps

module sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // The first stage feeds only the second stage.
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_state_t;

  sync_state_t stage;       // Registered chain.
  sync_state_t next_stage;  // Next value of the chain.

  // Shift the input one stage per clock.
  always_comb begin
    next_stage.first  = async_in;
    next_stage.second = stage.first;
  end

  // Register the chain; reset clears both stages.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      stage <= '0;
    end else begin
      stage <= next_stage;
    end
  end

  assign sync_out = stage.second;

endmodule : sync2

// [src/sar_engine.sv]
// Successive approximation engine resolving one held sample bit by bit.
`timescale 1ns/1ps
`include "sar_readout_defs.svh"

module sar_engine (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        begin_conv,
  input  wire logic [17:0] sample,
  output logic             done,
  output logic [17:0]      result
);

  sar_readout_pkg::sar_t sar;       // Registered engine state.
  sar_readout_pkg::sar_t next_sar;  // Next engine state.
  logic [17:0]           trial;     // Code with the current bit tried.

  // One binary-weighted decision per clock, heaviest first.
  always_comb begin
    next_sar      = sar;
    next_sar.done = 1'b0;
    trial         = sar.code | (18'h00001 << sar.index);
    if (begin_conv) begin
      // Offset binary makes the comparison a plain unsigned one.
      next_sar.busy   = 1'b1;
      next_sar.index  = `TOP_INDEX;
      next_sar.sample = sample ^ `SIGN_MASK;
      next_sar.code   = '0;
    end else if (sar.busy) begin
      if (sar.sample >= trial) begin
        next_sar.code = trial;
      end
      if (sar.index == 5'h00) begin
        next_sar.busy = 1'b0;
        next_sar.done = 1'b1;
      end else begin
        next_sar.index = sar.index - 5'h01;
      end
    end
  end

  // Register the engine state.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sar <= '0;
    end else begin
      sar <= next_sar;
    end
  end

  assign result = sar.code ^ `SIGN_MASK;
  assign done   = sar.done;

  a_sar_steps: assert property (@(posedge clock) disable iff (!resetn)
    begin_conv |-> ##19 done)
    else $error("conversion did not finish after eighteen steps");

  a_sar_exact: assert property (@(posedge clock) disable iff (!resetn)
    sar.done |-> (sar.code == sar.sample))
    else $error("resolved code differs from held sample");

  a_sar_coding: assert property (@(posedge clock) disable iff (!resetn)
    (begin_conv && sample == 18'h20000) |-> ##19 (result == 18'h20000))
    else $error("negative full scale not coded as top bit only");

endmodule : sar_engine

// [src/sar_conversion_serial_readout.sv]
// Conversion control and serial result readout of an 18-bit SAR converter.
// Operation
// - Start rising edge ends acquisition, starts conversion.
// - Eighteen binary-weighted decisions, heaviest first.
// - Result readable only after MSB-ready interval.
// - Each shift clock falling edge advances one bit.
// - Self-clocked and echoed-clock readout variants.
// - Eighteen-bit twos complement word, MSB first.
// - Output word belongs to its own start.
// - Start accepts single-ended or differential drive.
// - Up to five million conversions per second.
// - Negative full scale is top bit only.
// - Bits shift on shift clock falling edge.
// - Self-clocked frame has zero, then header 10.
// - Echoed mode returns clock, data on falling edge.
`timescale 1ns/1ps
`include "sar_readout_defs.svh"

module sar_conversion_serial_readout (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        shift_clock,
  input  wire logic        conversion_start_p,
  input  wire logic        conversion_start_n,
  input  wire logic [17:0] input_difference,
  input  wire logic        returned_clock_in,
  output logic             serial_data,
  output logic             returned_clock_out,
  output logic             returned_clock_oe
);

  // ----------------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------------

  // All pin levels pass through one shared two-stage chain.
  // The chain costs two clocks plus one for edge detection; the sequencer
  // takes those three clocks off its MSB-ready count so that the word is
  // still published one MSB-ready interval after the pin rises.
  // The input bus is sampled bit by bit, so the host must hold it steady
  // for a few clocks around the start edge; a code changing right at the
  // edge could be captured as a mix of old and new bits.
  logic [20:0] pins_sync;    // Synchronised pin levels.
  logic        start_p;      // Positive leg of the start input.
  logic        start_n;      // Negative leg of the start input.
  logic        strap_level;  // Level read back on the returned clock pin.
  logic [17:0] held_sample;  // Synchronised differential input.

  sync2 #(
    .WIDTH (21)
  ) u_pin_sync (
    .clock    (clock),
    .resetn   (resetn),
    .async_in ({returned_clock_in, conversion_start_n, conversion_start_p,
                input_difference}),
    .sync_out (pins_sync)
  );

  assign strap_level = pins_sync[20];
  assign start_n     = pins_sync[19];
  assign start_p     = pins_sync[18];
  assign held_sample = pins_sync[17:0];

  // ----------------------------------------------------------------------
  // Conversion engine
  // ----------------------------------------------------------------------

  logic        sar_begin;   // One-cycle pulse that captures the sample.
  logic        sar_done;    // One-cycle pulse when all bits are decided.
  logic [17:0] sar_result;  // Resolved word, twos complement.

  sar_engine u_sar (
    .clock      (clock),
    .resetn     (resetn),
    .begin_conv (sar_begin),
    .sample     (held_sample),
    .done       (sar_done),
    .result     (sar_result)
  );

  // ----------------------------------------------------------------------
  // Main-domain sequencer
  // ----------------------------------------------------------------------

  sar_readout_pkg::ctrl_t ctl;          // Registered sequencer state.
  sar_readout_pkg::ctrl_t next_ctl;     // Next sequencer state.
  logic                   start_level;  // Decoded start input level.
  logic                   start_rise;   // Rising edge of the start input.

  // either drive style
  // With the negative leg grounded this reduces to the positive leg alone,
  // so one expression serves both the single-ended and differential drive.
  assign start_level = start_p & ~start_n;
  assign start_rise  = start_level & ~ctl.start_prev;

  // Sequencer: strap, acquire, convert, then hold off until the next slot.
  // One timer serves every state: it counts the synchroniser fill in the
  // strap state, the MSB-ready interval while converting, and the rest of
  // the conversion slot while holding off. Acquire leaves it at the end of
  // the slot, which the start-rate check relies on.
  always_comb begin
    next_ctl            = ctl;
    next_ctl.start_prev = start_level;
    sar_begin           = 1'b0;
    case (ctl.state)
      sar_readout_pkg::ST_STRAP: begin
        // Wait for the synchroniser to fill before reading the strap.
        next_ctl.timer = ctl.timer + 6'h01;
        if (ctl.timer == `STRAP_COUNT) begin
          next_ctl.echo_mode = strap_level;
          next_ctl.timer     = `CONV_PERIOD_COUNT - 6'h01;
          next_ctl.state     = sar_readout_pkg::ST_ACQUIRE;
        end
      end
      sar_readout_pkg::ST_ACQUIRE: begin
        if (start_rise) begin
          sar_begin      = 1'b1;
          next_ctl.timer = 6'h01;
          next_ctl.state = sar_readout_pkg::ST_CONVERT;
        end
      end
      sar_readout_pkg::ST_CONVERT: begin
        next_ctl.timer = ctl.timer + 6'h01;
        if (ctl.timer == `MSB_READY_COUNT) begin
          next_ctl.result_word = sar_result;
          next_ctl.word_toggle = ~ctl.word_toggle;
          next_ctl.state       = sar_readout_pkg::ST_HOLDOFF;
        end
      end
      sar_readout_pkg::ST_HOLDOFF: begin
        // enforce the conversion slot
        // Starts arriving faster than the rated slot are ignored rather
        // than allowed to disturb the word that is being read out.
        if (ctl.timer == `CONV_PERIOD_COUNT - 6'h01) begin
          next_ctl.state = sar_readout_pkg::ST_ACQUIRE;
        end else begin
          next_ctl.timer = ctl.timer + 6'h01;
        end
      end
      default: begin
        next_ctl.state = sar_readout_pkg::ST_STRAP;
        next_ctl.timer = '0;
      end
    endcase
  end

  // Register the sequencer state.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctl       <= '0;
      ctl.state <= sar_readout_pkg::ST_STRAP;
    end else begin
      ctl <= next_ctl;
    end
  end

  // The pin is only driven once echoed-clock mode has been read back.
  assign returned_clock_oe = ctl.echo_mode;

  // ----------------------------------------------------------------------
  // Shift-clock domain
  // ----------------------------------------------------------------------

  sar_readout_pkg::link_t  lnk;       // Registered serial output state.
  sar_readout_pkg::link_t  next_lnk;  // Next serial output state.
  logic [`FRAME_WIDTH-1:0] frame;     // Bits of the word in output order.

  // The frame is left-aligned: the first bit to leave is always bit 19.
  // In echoed-clock mode the two spare low bits are never shifted out,
  // because the burst length there is eighteen edges.
  // variant frame layout
  assign frame = ctl.echo_mode ? {ctl.result_word, 2'h0}
                               : {`SELF_HEADER, ctl.result_word};

  // quasi-static word crossing
  // The word and its toggle settle within the MSB-ready interval, before the host
  // may clock, and the shift clock stands still meanwhile, so the falling
  // edge reads them safely. A synchroniser here would swallow the first
  // edges of every burst, because the link clock does not run free.
  always_comb begin
    next_lnk = lnk;
    if (ctl.word_toggle != lnk.seen_toggle) begin
      // First edge of a burst: launch the first bit of the new frame.
      next_lnk.seen_toggle = ctl.word_toggle;
      next_lnk.serial_data = frame[`FRAME_WIDTH-1];
      next_lnk.shreg       = {frame[`FRAME_WIDTH-2:0], 1'b0};
      next_lnk.remaining   = ctl.echo_mode ? `ECHO_LAST : `SELF_LAST;
    end else if (lnk.remaining != 5'h00) begin
      next_lnk.serial_data = lnk.shreg[`FRAME_WIDTH-1];
      next_lnk.shreg       = {lnk.shreg[`FRAME_WIDTH-2:0], 1'b0};
      next_lnk.remaining   = lnk.remaining - 5'h01;
    end else begin
      // Extra edges give the leading zero of the next self-clocked frame.
      next_lnk.serial_data = 1'b0;
    end
  end

  always_ff @(negedge shift_clock or negedge resetn) begin
    if (!resetn) begin
      lnk <= '0;
    end else begin
      lnk <= next_lnk;
    end
  end

  assign serial_data = lnk.serial_data;

  // echo copy of clock
  // A gated copy of the shift clock; held low in self-clocked mode.
  // A register cannot copy a clock edge for edge, so this output is the one
  // path of the block that is not a flip-flop. The enable only changes while
  // the strap is read, when the host keeps the shift clock still, so the
  // gate cannot clip a pulse.
  assign returned_clock_out = shift_clock & ctl.echo_mode;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------

  // Main-domain checks sample on the clock; link checks sample on the falling
  // shift clock edge, the edge that launches each bit, so they only run while
  // the host bursts.
  a_start_taken: assert property (@(posedge clock) disable iff (!resetn)
    (ctl.state == sar_readout_pkg::ST_ACQUIRE && start_rise)
      |-> sar_begin ##1 (ctl.state == sar_readout_pkg::ST_CONVERT))
    else $error("start edge did not begin a conversion");

  a_msb_ready: assert property (@(posedge clock) disable iff (!resetn)
    (ctl.state == sar_readout_pkg::ST_CONVERT && ctl.timer < `MSB_READY_COUNT)
      |=> $stable(ctl.word_toggle))
    else $error("word published before the MSB-ready interval");

  // The word is registered on the clock after the timer reaches its count, so
  // the new toggle is first sampled twenty-three clocks after the start.
  a_word_publish: assert property (@(posedge clock) disable iff (!resetn)
    sar_begin |-> ##23 (ctl.word_toggle != $past(ctl.word_toggle))
      ##0 (ctl.result_word == $past(sar_result)))
    else $error("word of this conversion not published on time");

  a_start_rate: assert property (@(posedge clock) disable iff (!resetn)
    sar_begin |-> (ctl.timer == `CONV_PERIOD_COUNT - 6'h01))
    else $error("conversion started inside the previous slot");

  a_header_order: assert property (@(negedge shift_clock) disable iff (!resetn)
    (ctl.word_toggle != lnk.seen_toggle && !ctl.echo_mode)
      |=> serial_data ##1 !serial_data)
    else $error("self-clocked header is not 10");

  a_echo_msb: assert property (@(negedge shift_clock) disable iff (!resetn)
    (ctl.word_toggle != lnk.seen_toggle && ctl.echo_mode)
      |=> (serial_data == ctl.result_word[17]))
    else $error("echoed-clock burst does not open with the MSB");

  a_shift_step: assert property (@(negedge shift_clock) disable iff (!resetn)
    (ctl.word_toggle == lnk.seen_toggle && lnk.remaining != 5'h00)
      |=> (serial_data == $past(lnk.shreg[19])))
    else $error("serial data did not advance by one bit");

  // Once the strap has been read the variant can no longer change, since the
  // host capture logic was built for one variant only.
  a_mode_fixed: assert property (@(posedge clock) disable iff (!resetn)
    (ctl.state != sar_readout_pkg::ST_STRAP) |=> $stable(ctl.echo_mode))
    else $error("readout variant changed after the strap was read");

  // A published word stands until the next conversion replaces it.
  a_word_stands: assert property (@(posedge clock) disable iff (!resetn)
    (ctl.state != sar_readout_pkg::ST_CONVERT) |=> $stable(ctl.result_word))
    else $error("published word changed outside a conversion");

  // Starts that arrive inside the slot must not reach the engine.
  a_slot_refuse: assert property (@(posedge clock) disable iff (!resetn)
    (ctl.state == sar_readout_pkg::ST_HOLDOFF) |-> !sar_begin)
    else $error("start taken while the previous slot was still open");

  // Each burst loads exactly the bits of its variant's frame.
  a_frame_length: assert property (@(negedge shift_clock) disable iff (!resetn)
    (ctl.word_toggle != lnk.seen_toggle)
      |=> (lnk.remaining == (ctl.echo_mode ? 5'h11 : 5'h13)))
    else $error("burst loaded a frame of the wrong length");

  // In self-clocked mode the MSB follows the two header bits.
  a_self_msb: assert property (@(negedge shift_clock) disable iff (!resetn)
    (ctl.word_toggle != lnk.seen_toggle && !ctl.echo_mode)
      |=> ##2 (serial_data == ctl.result_word[17]))
    else $error("self-clocked frame does not carry the MSB after the header");

  // Edges beyond the frame give zeros, the leading zero of the next frame.
  a_idle_zero: assert property (@(negedge shift_clock) disable iff (!resetn)
    (ctl.word_toggle == lnk.seen_toggle && lnk.remaining == 5'h00)
      |=> !serial_data)
    else $error("serial data not low between frames");

endmodule : sar_conversion_serial_readout

// [testbench/host_capture.sv]
// Host-side model that starts conversions and captures serial results.
`timescale 1ns/1ps

module host_capture (
  input  wire logic clock,
  input  wire logic serial_data,
  input  wire logic returned_clock_out,
  output logic      shift_clock,
  output logic      conversion_start_p,
  output logic      conversion_start_n
);
  // ----------------------------------------------------------------
  // Model state
  // ----------------------------------------------------------------
  int echo_bad; // Returned-clock samples that disagreed with the burst.

  initial begin
    shift_clock        = 1'b0;
    conversion_start_p = 1'b0;
    conversion_start_n = 1'b0;
    echo_bad           = 0;
  end

  task automatic set_drive(input logic diff);
    @(posedge clock) #1;
    conversion_start_n = diff;
  endtask : set_drive

  // start pulse.
  // The pulse goes low again well inside the slot, so edge detection sees every start.
  task automatic pulse_start(input logic diff);
    @(posedge clock) #1;
    conversion_start_p = 1'b1;
    conversion_start_n = 1'b0;
    repeat (10) @(posedge clock);
    #1;
    conversion_start_p = 1'b0;
    conversion_start_n = diff;
  endtask : pulse_start

  // burst and capture.
  // The clock stands low outside a burst; bits are taken 24 ns after each fall.
  task automatic burst(input int edges, input logic echo, output logic [20:0] bits);
    bits = '0;
    #7;
    for (int i = 0; i < edges; i++) begin
      shift_clock = 1'b1;
      #12;
      if (returned_clock_out !== echo) begin
        echo_bad++;
      end
      #12;
      shift_clock = 1'b0;
      #12;
      if (returned_clock_out !== 1'b0) begin
        echo_bad++;
      end
      #12;
      bits = {bits[19:0], serial_data};
    end
  endtask : burst
endmodule : host_capture

// [testbench/test_sar_conversion_serial_readout.sv]
// Self-checking testbench of the conversion control and serial readout block.
`timescale 1ns/1ps

module test_sar_conversion_serial_readout;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clock;              // Main clock, 4 ns.
  logic        resetn;             // Asynchronous reset, active low.
  logic        strap_level;        // Board level of the returned clock pin when released.
  logic [17:0] input_difference;   // Held input code.
  logic        shift_clock;        // Burst clock from the host model.
  logic        conversion_start_p; // Start pair, positive leg.
  logic        conversion_start_n; // Start pair, negative leg.
  logic        returned_clock_in;  // Resolved level of the returned clock pin.
  logic        serial_data;        // Serial result.
  logic        returned_clock_out; // Echoed clock.
  logic        returned_clock_oe;  // Device drives the returned clock pin.
  int          bad_count;          // Mismatches seen.
  int          n_tests;            // Comparisons made.
  logic [17:0] codes [8];          // Codes swept in each mode.

  // The pin shows the device's drive when enabled, else the board strap.
  assign returned_clock_in = returned_clock_oe ? returned_clock_out : strap_level;

  sar_conversion_serial_readout i_dut (
    .clock              (clock),
    .resetn             (resetn),
    .shift_clock        (shift_clock),
    .conversion_start_p (conversion_start_p),
    .conversion_start_n (conversion_start_n),
    .input_difference   (input_difference),
    .returned_clock_in  (returned_clock_in),
    .serial_data        (serial_data),
    .returned_clock_out (returned_clock_out),
    .returned_clock_oe  (returned_clock_oe)
  );

  host_capture i_host (
    .clock              (clock),
    .serial_data        (serial_data),
    .returned_clock_out (returned_clock_out),
    .shift_clock        (shift_clock),
    .conversion_start_p (conversion_start_p),
    .conversion_start_n (conversion_start_n)
  );

  // Main clock at 250 MHz.
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [20:0] seen, input logic [20:0] expected, input string what);
    n_tests++;
    if (seen !== expected) begin
      bad_count++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, expected);
    end
  endtask : check

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  // Reset with the strap at the given level; the mode is read after release.
  task automatic do_reset(input logic strap);
    @(posedge clock) #1;
    resetn      = 1'b0;
    strap_level = strap;
    repeat (6) @(posedge clock);
    #1;
    resetn = 1'b1;
    repeat (12) @(posedge clock);
    #1;
    check({20'h0, serial_data}, 21'h0, "idle data");
    check({20'h0, returned_clock_oe}, {20'h0, strap}, "pin drive");
  endtask : do_reset

  // One conversion of a code and its readout; the word must be the same start's.
  task automatic convert_read(input logic [17:0] code, input logic echo, input logic diff);
    logic [20:0] bits;
    @(posedge clock) #1;
    input_difference = code;
    repeat (5) @(posedge clock);
    i_host.pulse_start(diff);
    repeat (20) @(posedge clock);
    i_host.burst(echo ? 19 : 21, echo, bits);
    if (echo) begin
      check(bits, {2'h0, code, 1'b0}, "echo frame");
    end else begin
      check(bits, {2'h2, code, 1'b0}, "self frame");
    end
  endtask : convert_read

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // self-clocked code sweep.
  task automatic test_self_codes();
    do_reset(1'b0);
    foreach (codes[i]) begin
      convert_read(codes[i], 1'b0, 1'b0);
    end
    check(21'(i_host.echo_bad), 21'h0, "quiet pin");
  endtask : test_self_codes

  // echoed-clock sweep with differential start drive.
  task automatic test_echo_codes();
    do_reset(1'b1);
    i_host.set_drive(1'b1);
    foreach (codes[i]) begin
      convert_read(codes[i], 1'b1, 1'b1);
    end
    check(21'(i_host.echo_bad), 21'h0, "echo copy");
    i_host.set_drive(1'b0);
  endtask : test_echo_codes

  // a start inside the slot is ignored, the next one is paired.
  task automatic test_early_start();
    logic [20:0] bits;
    do_reset(1'b0);
    @(posedge clock) #1;
    input_difference = 18'h2AAAA;
    repeat (5) @(posedge clock);
    i_host.pulse_start(1'b0);
    input_difference = 18'h15555;
    repeat (10) @(posedge clock);
    i_host.pulse_start(1'b0);
    repeat (20) @(posedge clock);
    i_host.burst(21, 1'b0, bits);
    check(bits, {2'h2, 18'h2AAAA, 1'b0}, "early start");
    convert_read(18'h15555, 1'b0, 1'b0);
  endtask : test_early_start

  // Watchdog: the sequence needs about 20 us.
  initial begin
    #200000;
    bad_count++;
    finish_test();
  end

  // Main sequence.
  initial begin
    resetn           = 1'b0;
    strap_level      = 1'b0;
    input_difference = 18'h00000;
    bad_count        = 0;
    n_tests          = 0;
    codes = '{18'h20000, 18'h1FFFF, 18'h00000, 18'h3FFFF,
              18'h20001, 18'h00001, 18'h2AAAA, 18'h15555};
    test_self_codes();
    test_echo_codes();
    test_early_start();
    finish_test();
  end
endmodule : test_sar_conversion_serial_readout
